// ===== inc/mgbr_pkg.sv
// mixer gain and beep register bank: shared constants and types
// Contract
// - beep gain code steps 3.0 dB attenuation each, 0 dB to 45 dB.
// - tone toggles every 2*divisor base-rate ticks; zero divisor stops the tone.
// - generated tone is a square wave at the programmed frequency.
// - beep source select 0 takes internal tone, 1 takes analog beep input.
// - while reset is held, only the beep_reset_bypass flag is raised; beep_active reads low.
// - beep mute bit silences beep of either source; resets to one.
// - phone gain code: +12 dB at zero, -1.5 dB per code, code 8 is 0 dB.
// - stereo input gain codes decode +12 dB down 1.5 dB per code to -34.5.
// - input gains touch mixer path only, never the record converter gain.
// - boost off gives 0 dB; on gives 20 dB, as the select field has no bit and reads 00.
// - front converter register sets that output's mixer gain and mute.
// - record source chosen per channel by 3-bit fields; register resets to zero.
// - left record code 000 is microphone selector, 001 is compact disc left.
package mgbr_pkg;

  // ----------------------------------------------------------------
  // register indices (16-bit register space)
  // ----------------------------------------------------------------
  localparam logic [6:0] MGBR_OFS_BEEP = 7'h0A;
  localparam logic [6:0] MGBR_OFS_PHONE = 7'h0C;
  localparam logic [6:0] MGBR_OFS_MIC = 7'h0E;
  localparam logic [6:0] MGBR_OFS_LINE = 7'h10;
  localparam logic [6:0] MGBR_OFS_CD = 7'h12;
  localparam logic [6:0] MGBR_OFS_AUX = 7'h16;
  localparam logic [6:0] MGBR_OFS_FRONT = 7'h18;
  localparam logic [6:0] MGBR_OFS_RECSEL = 7'h1A;

  // ----------------------------------------------------------------
  // reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] MGBR_RST_BEEP = 16'h8000;
  localparam logic [15:0] MGBR_RST_PHONE = 16'h8008;
  localparam logic [15:0] MGBR_RST_STEREO = 16'h8888;
  localparam logic [15:0] MGBR_RST_RECSEL = 16'h0000;
  localparam logic [15:0] MGBR_MSK_BEEP = 16'hDFFE;
  localparam logic [15:0] MGBR_MSK_PHONE = 16'h801F;
  localparam logic [15:0] MGBR_MSK_STEREO = 16'h9F9F;
  localparam logic [15:0] MGBR_MSK_MIC = 16'h9FDF;
  localparam logic [15:0] MGBR_MSK_RECSEL = 16'h0707;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MGBR_BIT_MUTE_L = 15;
  localparam int MGBR_BIT_BEEP_SRC = 14;
  localparam int MGBR_POS_DIV = 5;
  localparam int MGBR_POS_BEEP_GAIN = 1;
  localparam int MGBR_POS_GAIN_L = 8;
  localparam int MGBR_BIT_MUTE_R = 7;
  localparam int MGBR_BIT_BOOST_EN = 6;
  localparam int MGBR_POS_REC_L = 8;

  // ----------------------------------------------------------------
  // tone timing: base-rate tick 48 kHz from 200 MHz clock
  // ----------------------------------------------------------------
  localparam int MGBR_CLK_HZ = 200000000;
  localparam int MGBR_BASE_HZ = 48000;
  localparam int MGBR_TICK_CYC = MGBR_CLK_HZ / MGBR_BASE_HZ;
  localparam int MGBR_DIV_MULT = 4;
  localparam logic [15:0] MGBR_BOOST_DB_20 = 16'h0014;
  localparam logic [15:0] MGBR_BOOST_DB_10 = 16'h000A;
  localparam int MGBR_NUM_STEREO = 5;

  typedef enum logic [1:0] {MGBR_BOOST_20, MGBR_BOOST_10, MGBR_BOOST_RSV2, MGBR_BOOST_RSV3}
    mgbr_boost_t;

endpackage

// ===== inc/mgbr_tone_if.sv
// carrier between register bank and tone generator
`timescale 1ns/10ps
interface mgbr_tone_if;
  logic [7:0] divisor;
  logic tone;
  logic running;
  modport ctrl (output divisor, input tone, input running);
  modport gen (input divisor, output tone, output running);
endinterface

// ===== rtl/mgbr_tone_gen.sv
// square-wave beep tone generator
`timescale 1ns/10ps
module mgbr_tone_gen
  import mgbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  mgbr_tone_if.gen tif
);

  typedef struct packed {
    logic [12:0] tick_cnt;
    logic [9:0] half_cnt;
    logic tone;
  } mgbr_tone_st_t;

  mgbr_tone_st_t st_r;
  mgbr_tone_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (tif.divisor == 8'h00)
    begin
      // zero divisor parks the generator low
      st_nxt = '0;
    end
    else if (st_r.tick_cnt == 13'(MGBR_TICK_CYC - 1))
    begin
      st_nxt.tick_cnt = '0;
      // half period of 2*divisor ticks: full period is 4*divisor ticks
      if (st_r.half_cnt >= {1'b0, tif.divisor, 1'b0} - 10'h001)
      begin
        st_nxt.half_cnt = '0;
        st_nxt.tone = ~st_r.tone;
      end
      else
      begin
        st_nxt.half_cnt = st_r.half_cnt + 10'h001;
      end
    end
    else
    begin
      st_nxt.tick_cnt = st_r.tick_cnt + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tif.tone = st_r.tone;
  assign tif.running = (tif.divisor != 8'h00);

endmodule

// ===== rtl/mgbr_regs.sv
// mixer gain and beep register bank with beep routing
`timescale 1ns/10ps
module mgbr_regs
  import mgbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic analog_beep_input,
  output logic beep_active,
  output logic beep_reset_bypass,
  output logic [3:0] beep_atten_code,
  output logic phone_mute,
  output logic [4:0] phone_gain_code,
  output logic [MGBR_NUM_STEREO-1:0] left_channel_mute,
  output logic [MGBR_NUM_STEREO-1:0] right_channel_mute,
  output logic [MGBR_NUM_STEREO*5-1:0] left_gain_code,
  output logic [MGBR_NUM_STEREO*5-1:0] right_gain_code,
  output logic [15:0] mic_boost_db,
  output logic [2:0] left_record_source,
  output logic [2:0] right_record_source
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // stereo index: 0 mic, 1 line, 2 cd, 3 aux, 4 front converter
  typedef struct packed {
    logic [15:0] beep;
    logic [15:0] phone;
    logic [MGBR_NUM_STEREO-1:0][15:0] stereo;
    logic [15:0] recsel;
    logic [15:0] rdata;
    logic rvalid;
    logic beep_active;
    logic beep_bypass;
    logic [3:0] beep_atten;
    logic [15:0] boost_db;
  } mgbr_state_t;

  mgbr_state_t st_r;
  mgbr_state_t st_nxt;

  mgbr_tone_if tif ();

  mgbr_tone_gen i_mgbr_tone_gen (
    .ref_clk(ref_clk),
    .srst(srst),
    .tif(tif)
  );

  assign tif.divisor = st_r.beep[MGBR_POS_DIV +: 8];

  // stereo entry of each gain register
  localparam int MGBR_IDX_MIC = 0;
  localparam int MGBR_IDX_LINE = 1;
  localparam int MGBR_IDX_CD = 2;
  localparam int MGBR_IDX_AUX = 3;
  localparam int MGBR_IDX_FRONT = 4;

  // ----------------------------------------------------------------
  // per-channel output fields
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < MGBR_NUM_STEREO; gi++)
    begin : g_stereo
      // independent left and right mutes, gain decoded downstream
      assign left_channel_mute[gi] = st_r.stereo[gi][MGBR_BIT_MUTE_L];
      assign right_channel_mute[gi] = st_r.stereo[gi][MGBR_BIT_MUTE_R];
      assign left_gain_code[gi*5 +: 5] = st_r.stereo[gi][MGBR_POS_GAIN_L +: 5];
      assign right_gain_code[gi*5 +: 5] = st_r.stereo[gi][4:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic beep_sig;
  mgbr_boost_t boost_sel;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    beep_sig = 1'b0;
    // the boost gain select field has no bit in this bank, so it reads as 00
    boost_sel = MGBR_BOOST_20;

    // ----------------------------------------------------------------
    // write decode: reserved bits are masked off on every write
    // ----------------------------------------------------------------
    if (reg_wr)
    begin
      case (reg_addr)
        MGBR_OFS_BEEP:
        begin
          st_nxt.beep = reg_wdata & MGBR_MSK_BEEP;
        end
        MGBR_OFS_PHONE:
        begin
          st_nxt.phone = reg_wdata & MGBR_MSK_PHONE;
        end
        MGBR_OFS_MIC:
        begin
          // boost enable is the one extra writable bit of the microphone pair
          st_nxt.stereo[MGBR_IDX_MIC] = reg_wdata & MGBR_MSK_MIC;
        end
        MGBR_OFS_LINE:
        begin
          st_nxt.stereo[MGBR_IDX_LINE] = reg_wdata & MGBR_MSK_STEREO;
        end
        MGBR_OFS_CD:
        begin
          st_nxt.stereo[MGBR_IDX_CD] = reg_wdata & MGBR_MSK_STEREO;
        end
        MGBR_OFS_AUX:
        begin
          st_nxt.stereo[MGBR_IDX_AUX] = reg_wdata & MGBR_MSK_STEREO;
        end
        MGBR_OFS_FRONT:
        begin
          st_nxt.stereo[MGBR_IDX_FRONT] = reg_wdata & MGBR_MSK_STEREO;
        end
        MGBR_OFS_RECSEL:
        begin
          st_nxt.recsel = reg_wdata & MGBR_MSK_RECSEL;
        end
        default:
        begin
          // unmapped index: the write is dropped and no field moves
        end
      endcase
    end

    // ----------------------------------------------------------------
    // read mux: a read in the same cycle as a write returns the old word
    // ----------------------------------------------------------------
    if (reg_rd)
    begin
      st_nxt.rvalid = 1'b1;
      case (reg_addr)
        MGBR_OFS_BEEP:
        begin
          st_nxt.rdata = st_r.beep;
        end
        MGBR_OFS_PHONE:
        begin
          st_nxt.rdata = st_r.phone;
        end
        MGBR_OFS_MIC:
        begin
          st_nxt.rdata = st_r.stereo[MGBR_IDX_MIC];
        end
        MGBR_OFS_LINE:
        begin
          st_nxt.rdata = st_r.stereo[MGBR_IDX_LINE];
        end
        MGBR_OFS_CD:
        begin
          st_nxt.rdata = st_r.stereo[MGBR_IDX_CD];
        end
        MGBR_OFS_AUX:
        begin
          st_nxt.rdata = st_r.stereo[MGBR_IDX_AUX];
        end
        MGBR_OFS_FRONT:
        begin
          st_nxt.rdata = st_r.stereo[MGBR_IDX_FRONT];
        end
        MGBR_OFS_RECSEL:
        begin
          st_nxt.rdata = st_r.recsel;
        end
        default:
        begin
          st_nxt.rdata = 16'h0000;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // beep routing
    // ----------------------------------------------------------------
    if (st_r.beep[MGBR_BIT_BEEP_SRC])
    begin
      beep_sig = analog_beep_input;
    end
    else
    begin
      // a parked generator reads as silence, whatever its last level was
      beep_sig = tif.running & tif.tone;
    end
    st_nxt.beep_active = beep_sig & ~st_r.beep[MGBR_BIT_MUTE_L];
    // only the reset branch raises the bypass flag
    st_nxt.beep_bypass = 1'b0;
    st_nxt.beep_atten = st_r.beep[MGBR_POS_BEEP_GAIN +: 4];

    // ----------------------------------------------------------------
    // microphone boost, shared by both channels
    // ----------------------------------------------------------------
    st_nxt.boost_db = 16'h0000;
    if (st_r.stereo[MGBR_IDX_MIC][MGBR_BIT_BOOST_EN])
    begin
      case (boost_sel)
        MGBR_BOOST_20:
        begin
          st_nxt.boost_db = MGBR_BOOST_DB_20;
        end
        MGBR_BOOST_10:
        begin
          st_nxt.boost_db = MGBR_BOOST_DB_10;
        end
        default:
        begin
          st_nxt.boost_db = MGBR_BOOST_DB_20;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.beep <= MGBR_RST_BEEP;
      st_r.phone <= MGBR_RST_PHONE;
      for (int i = 0; i < MGBR_NUM_STEREO; i++)
        st_r.stereo[i] <= MGBR_RST_STEREO;
      st_r.recsel <= MGBR_RST_RECSEL;
      // during reset only the bypass flag is raised; the analog pin is not routed here
      st_r.beep_bypass <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign beep_active = st_r.beep_active;
  assign beep_reset_bypass = st_r.beep_bypass;
  assign beep_atten_code = st_r.beep_atten;
  // phone code 8 is unity; this path feeds the mixer only, record gain lives elsewhere
  assign phone_mute = st_r.phone[MGBR_BIT_MUTE_L];
  assign phone_gain_code = st_r.phone[4:0];
  assign mic_boost_db = st_r.boost_db;
  // left code 000 is the microphone selector, 001 the compact disc left side
  assign left_record_source = st_r.recsel[MGBR_POS_REC_L +: 3];
  assign right_record_source = st_r.recsel[2:0];

endmodule

// ===== tb/mgbr_regs_chk.sv
// port-level assertions for the mixer gain and beep register bank
`timescale 1ns/10ps
module mgbr_regs_chk
  import mgbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic beep_active,
  input wire logic beep_reset_bypass,
  input wire logic phone_mute,
  input wire logic [4:0] phone_gain_code,
  input wire logic [MGBR_NUM_STEREO*5-1:0] left_gain_code,
  input wire logic [2:0] left_record_source,
  input wire logic [2:0] right_record_source
);
  default clocking @(posedge ref_clk);
  endclocking

  a_read_answer: assert property (disable iff (srst) reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  a_bypass_reset: assert property (srst |=> beep_reset_bypass)
    else $error("beep bypass low while reset held");
  a_bypass_release: assert property (!srst |=> !beep_reset_bypass)
    else $error("beep bypass high outside reset");
  a_mute_default: assert property (srst |=> !beep_active && phone_mute)
    else $error("mutes not set by reset");
  a_beep_mute: assert property (disable iff (srst)
    (reg_wr && reg_addr == MGBR_OFS_BEEP && reg_wdata[15]) |-> ##2 !beep_active)
    else $error("beep sounds while muted");
  a_phone_field: assert property (disable iff (srst)
    (reg_wr && reg_addr == MGBR_OFS_PHONE)
    |=> {phone_mute, phone_gain_code} == {$past(reg_wdata[15]), $past(reg_wdata[4:0])})
    else $error("phone gain fields wrong after write");
  a_line_gain: assert property (disable iff (srst)
    (reg_wr && reg_addr == MGBR_OFS_LINE)
    |=> left_gain_code[9:5] == $past(reg_wdata[12:8]))
    else $error("line left gain wrong after write");
  a_record_src: assert property (disable iff (srst)
    (reg_wr && reg_addr == MGBR_OFS_RECSEL)
    |=> {left_record_source, right_record_source} == {$past(reg_wdata[10:8]),
    $past(reg_wdata[2:0])})
    else $error("record source fields wrong after write");
endmodule

bind mgbr_regs mgbr_regs_chk i_mgbr_regs_chk (.ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rvalid, .beep_active, .beep_reset_bypass, .phone_mute, .phone_gain_code,
  .left_gain_code, .left_record_source, .right_record_source);

// ===== tb/mgbr_ctrl_model.sv
// controller-side model issuing register writes and reads
`timescale 1ns/10ps
module mgbr_ctrl_model
  import mgbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge ref_clk);
      ok = reg_rvalid === 1'b1;
      d = reg_rdata;
    end
  endtask

  // boot sequence: analog beep source, beep unmuted, both mic channels alike
  task automatic startup();
    wr(MGBR_OFS_BEEP, 16'h4000);
    wr(MGBR_OFS_MIC, 16'h0808);
  endtask
endmodule

// ===== tb/tb_mgbr_regs.sv
// self-checking bench for the mixer gain and beep register bank
`timescale 1ns/10ps
module tb_mgbr_regs;
  import mgbr_pkg::*;
  localparam logic [6:0] OFS [8] = '{7'h0A, 7'h0C, 7'h0E, 7'h10, 7'h12, 7'h16, 7'h18, 7'h1A};
  localparam logic [15:0] RST [8] = '{16'h8000, 16'h8008, 16'h8888, 16'h8888, 16'h8888,
    16'h8888, 16'h8888, 16'h0000};
  localparam logic [15:0] MSK [8] = '{16'hDFFE, 16'h801F, 16'h9FDF, 16'h9F9F, 16'h9F9F,
    16'h9F9F, 16'h9F9F, 16'h0707};
  logic ref_clk, srst, reg_wr, reg_rd, reg_rvalid, analog_beep_input, beep_active;
  logic beep_reset_bypass, phone_mute;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mic_boost_db;
  logic [3:0] beep_atten_code;
  logic [4:0] phone_gain_code, left_channel_mute, right_channel_mute;
  logic [24:0] left_gain_code, right_gain_code;
  logic [2:0] left_record_source, right_record_source;
  int n_errors, cmp_count, h;
  logic [15:0] rec_view, line_view;

  assign rec_view = {5'h00, left_record_source, 5'h00, right_record_source};
  assign line_view = {1'b0, left_gain_code[9:5], right_gain_code[9:5], left_channel_mute};

  mgbr_regs i_mgbr_regs (.ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .analog_beep_input, .beep_active, .beep_reset_bypass, .beep_atten_code,
    .phone_mute, .phone_gain_code, .left_channel_mute, .right_channel_mute, .left_gain_code,
    .right_gain_code, .mic_boost_db, .left_record_source, .right_record_source);
  mgbr_ctrl_model i_mgbr_ctrl_model (.ref_clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic results();
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_mgbr_ctrl_model.wr(a, d);
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    i_mgbr_ctrl_model.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      n_errors++;
      results();
    end
    chk("rdata", e, d);
  endtask

  // cycles until the beep output changes, capped at 9000
  task automatic span(output int n);
    logic v;
    v = beep_active;
    n = 0;
    while (beep_active === v && n < 9000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  initial
  begin
    srst = 1'b1;
    analog_beep_input = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    chk("bypass", 16'h0001, 16'(beep_reset_bypass));
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("bypass", 16'h0000, 16'(beep_reset_bypass));
    for (int i = 0; i < 8; i++)
    begin
      rdc(OFS[i], RST[i]);
      wr(OFS[i], 16'hFFFF);
      rdc(OFS[i], MSK[i]);
    end
    wr(7'h14, 16'hFFFF);
    rdc(7'h14, 16'h0000);
    for (int c = 0; c < 8; c++)
    begin
      wr(MGBR_OFS_RECSEL, {5'h00, c[2:0], 5'h00, ~c[2:0]});
      chk("record", 16'(c * 255 + 7), rec_view);
    end
    for (int c = 0; c < 32; c++)
    begin
      wr(MGBR_OFS_PHONE, 16'(c));
      chk("phone", 16'(c), {phone_mute, 10'h000, phone_gain_code});
    end
    wr(MGBR_OFS_LINE, 16'h1F00);
    wr(MGBR_OFS_FRONT, 16'h8005);
    chk("line", 16'h7C1D, line_view);
    chk("front", 16'h15BC, {1'b0, right_gain_code[24:20], right_channel_mute, 5'h1C});
    chk("record kept", 16'h0700, rec_view);
    for (int b = 0; b < 2; b++)
    begin
      wr(MGBR_OFS_MIC, 16'(b * 64));
      repeat (2) @(posedge ref_clk);
      chk("boost", 16'(b * 20), mic_boost_db);
    end
    i_mgbr_ctrl_model.startup();
    for (int b = 0; b < 4; b++)
    begin
      if (b == 2)
        wr(MGBR_OFS_BEEP, 16'hC000);
      analog_beep_input <= b[0];
      repeat (3) @(posedge ref_clk);
      chk("beep", 16'(b[0] & (b < 2)), 16'(beep_active));
    end
    wr(MGBR_OFS_BEEP, 16'h001E);
    repeat (2) @(posedge ref_clk);
    chk("atten", 16'h000F, 16'(beep_atten_code));
    wr(MGBR_OFS_BEEP, 16'h0020);
    span(h);
    for (int k = 0; k < 2; k++)
    begin
      span(h);
      chk("half period", 16'(2 * MGBR_TICK_CYC), 16'(h));
      if (h >= 9000)
        results();
    end
    wr(MGBR_OFS_BEEP, 16'h0000);
    repeat (20) @(posedge ref_clk);
    span(h);
    chk("stopped tone", 16'h2328, 16'(h));
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("bypass", 16'h0001, 16'(beep_reset_bypass));
    srst <= 1'b0;
    rdc(MGBR_OFS_BEEP, 16'h8000);
    results();
  end
endmodule
